// ===== src/mit_core.sv
// instruction length, cycle timing, port read-modify-write and add flags
// Behaviour
// RULE1 - rotates, register moves, carry ops, nop: 1/1
// RULE2 - indirect moves and exchanges: one byte, two cycles
// RULE3 - direct-direct, immediate-direct 3/3; others 2/2
// RULE4 - data pointer immediate load: three bytes, three cycles
// RULE5 - code memory loads: one byte, four cycles
// RULE6 - extended data moves: one byte, four cycles
// RULE7 - push and pop: two bytes, two cycles
// RULE8 - direct bit operations: two bytes, two cycles
// RULE9 - short and conditional jumps take three cycles
// RULE10 - long jump, call, returns take four cycles
// RULE11 - bit jumps 3/4; test-clear jump clears bit
// RULE12 - compare jump unequal: three bytes, four cycles
// RULE13 - decrement jump: register 2/3, direct 3/4
// RULE14 - absolute call and jump: two bytes, three
// RULE15 - rmw port destination reads the output latch
// RULE16 - plain port input reads the pin
// RULE17 - rmw set: logic, inc, dec, bit writes
// RULE18 - bit writes rewrite whole latch byte
// RULE19 - add ignores carry in, carry from bit 7
// RULE20 - signed wrap: carries from bit 6 xor 7
// RULE21 - half carry from bit 3 into 4
// RULE22 - next fetch only after cycle count elapses
`default_nettype none
module mit_core (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // instruction issue
  input wire logic issue,
  input wire mit_pkg::mit_class_t op_class,
  input wire mit_pkg::mit_bit_func_t bit_func,
  input wire logic dest_is_port,
  input wire logic [7:0] mem_data,
  input wire logic carry_in,
  // port latch and pins
  input wire logic [7:0] port_latch,
  input wire logic [7:0] port_pin,
  input wire logic [2:0] bit_sel,
  // addition operands
  input wire logic add_go,
  input wire logic [7:0] add_a,
  input wire logic [7:0] add_b,
  // sequencing
  output logic fetch_ready,
  output logic busy,
  output mit_pkg::mit_info_t info,
  // operand and write-back
  output logic [7:0] operand,
  output logic bit_val,
  output logic [7:0] port_wr_data,
  output logic port_wr_en,
  // addition result
  output logic [7:0] add_sum,
  output mit_pkg::mit_flags_t add_flags
);
  import mit_pkg::*;

  function automatic mit_info_t decode(input mit_class_t c);
    mit_info_t r;
    r = '{known: 1'b1, len: LEN_ONE, cycles: CYC_ONE,
          rmw: 1'b0, bit_write: 1'b0};
    case (c)
      CL_NOP, CL_ROT_ACC, CL_REG_ACC, CL_CARRY_OP: begin
        r.len = LEN_ONE; // RULE1
        r.cycles = CYC_ONE;
      end
      CL_IND_MOVE, CL_IND_XCH, CL_NIBBLE_XCH: begin
        r.len = LEN_ONE; // RULE2
        r.cycles = CYC_TWO;
      end
      CL_DIR_DIR, CL_IMM_DIR: begin
        r.len = LEN_THREE; // RULE3
        r.cycles = CYC_THREE;
      end
      CL_TWO_BYTE_MOVE: begin
        r.len = LEN_TWO; // RULE3
        r.cycles = CYC_TWO;
      end
      CL_LOAD_PTR: begin
        r.len = LEN_THREE; // RULE4
        r.cycles = CYC_THREE;
      end
      CL_CODE_LOAD: begin
        r.len = LEN_ONE; // RULE5
        r.cycles = CYC_FOUR;
      end
      CL_EXT_MOVE: begin
        r.len = LEN_ONE; // RULE6
        r.cycles = CYC_FOUR;
      end
      CL_PUSH_POP: begin
        r.len = LEN_TWO; // RULE7
        r.cycles = CYC_TWO;
      end
      CL_BIT_WRITE: begin
        r.len = LEN_TWO; // RULE8
        r.cycles = CYC_TWO;
        r.rmw = 1'b1; // RULE17
        r.bit_write = 1'b1;
      end
      CL_BIT_LOGIC: begin
        r.len = LEN_TWO; // RULE8
        r.cycles = CYC_TWO;
      end
      CL_SHORT_BRANCH: begin
        r.len = LEN_TWO; // RULE9
        r.cycles = CYC_THREE;
      end
      CL_JUMP_INDIRECT: begin
        r.len = LEN_ONE; // RULE9
        r.cycles = CYC_THREE;
      end
      CL_LONG_JUMP: begin
        r.len = LEN_THREE; // RULE10
        r.cycles = CYC_FOUR;
      end
      CL_RETURN: begin
        r.len = LEN_ONE; // RULE10
        r.cycles = CYC_FOUR;
      end
      CL_BIT_JUMP: begin
        r.len = LEN_THREE; // RULE11
        r.cycles = CYC_FOUR;
      end
      CL_BIT_TEST_CLEAR: begin
        r.len = LEN_THREE; // RULE11
        r.cycles = CYC_FOUR;
        r.rmw = 1'b1; // RULE17
        r.bit_write = 1'b1;
      end
      CL_COMPARE_JUMP: begin
        r.len = LEN_THREE; // RULE12
        r.cycles = CYC_FOUR;
      end
      CL_DECREMENT_JUMP_NONZERO_REG: begin
        r.len = LEN_TWO; // RULE13
        r.cycles = CYC_THREE;
        r.rmw = 1'b1; // RULE17
      end
      CL_DECREMENT_JUMP_NONZERO_DIR: begin
        r.len = LEN_THREE; // RULE13
        r.cycles = CYC_FOUR;
        r.rmw = 1'b1; // RULE17
      end
      CL_ABS_JUMP: begin
        r.len = LEN_TWO; // RULE14
        r.cycles = CYC_THREE;
      end
      CL_RMW_BYTE: begin
        r.len = LEN_TWO;
        r.cycles = CYC_TWO;
        r.rmw = 1'b1; // RULE17
      end
      default: begin
        // unknown classes behave as a one-cycle no-op
        r.known = 1'b0;
      end
    endcase
    return r;
  endfunction

  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic accept;
  mit_info_t dec_now;
  logic rd_src;
  logic [7:0] rd_byte;
  logic new_bit;
  logic [7:0] bit_mask;
  logic [8:0] full_sum;
  logic [7:0] low7_sum;
  logic [4:0] nib_sum;

  // sequencing: one issue accepted only once the previous count is spent
  assign dec_now = decode(op_class);
  assign fetch_ready = (cnt_ff == CNT_RESET); // RULE22
  assign busy = !fetch_ready;
  assign accept = issue && fetch_ready; // RULE22
  assign nxt_cnt = accept ? dec_now.cycles - CYC_ONE :
                   (busy ? cnt_ff - CYC_ONE : cnt_ff);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_ff <= CNT_RESET;
    end else begin
      cnt_ff <= nxt_cnt; // RULE22
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      info <= '0;
    end else if (accept) begin
      info <= dec_now;
    end
  end

  // a port destination of an rmw op sees the latch; a driven pin may
  // be pulled away from the written level by its load
  assign rd_src = dest_is_port && dec_now.rmw;
  always_comb begin
    if (!dest_is_port) begin
      rd_byte = mem_data;
    end else if (rd_src) begin
      rd_byte = port_latch; // RULE15
    end else begin
      rd_byte = port_pin; // RULE16
    end
  end

  assign bit_mask = 8'h01 << bit_sel;
  always_comb begin
    case (bit_func)
      BF_CLEAR: new_bit = 1'b0;
      BF_SET: new_bit = 1'b1;
      BF_INVERT: new_bit = !rd_byte[bit_sel];
      BF_FROM_CARRY: new_bit = carry_in;
      default: new_bit = 1'b0;
    endcase
    if (op_class == CL_BIT_TEST_CLEAR) begin
      new_bit = 1'b0; // RULE11
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      operand <= BYTE_RESET;
      bit_val <= 1'b0;
    end else if (accept) begin
      operand <= rd_byte;
      bit_val <= rd_byte[bit_sel];
    end
  end

  // whole byte goes back; only the addressed bit differs
  always_ff @(posedge core_clk) begin
    if (rst) begin
      port_wr_data <= BYTE_RESET;
      port_wr_en <= 1'b0;
    end else begin
      port_wr_en <= accept && dest_is_port && dec_now.bit_write &&
                    (op_class != CL_BIT_TEST_CLEAR ||
                     rd_byte[bit_sel]); // RULE11
      if (accept && dec_now.bit_write) begin
        port_wr_data <= (rd_byte & ~bit_mask) |
                        (new_bit ? bit_mask : 8'h00); // RULE18
      end
    end
  end

  // addition: incoming carry deliberately not an operand
  assign full_sum = {1'b0, add_a} + {1'b0, add_b}; // RULE19
  assign low7_sum = {1'b0, add_a[6:0]} + {1'b0, add_b[6:0]};
  assign nib_sum = {1'b0, add_a[3:0]} + {1'b0, add_b[3:0]};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      add_sum <= BYTE_RESET;
      add_flags <= '0;
    end else if (add_go) begin
      add_sum <= full_sum[7:0];
      add_flags.carry <= full_sum[8]; // RULE19
      add_flags.signed_wrap_flag <= full_sum[8] ^ low7_sum[7]; // RULE20
      add_flags.half_carry_flag <= nib_sum[4]; // RULE21
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  logic [8:0] chk_sum;
  assign chk_sum = {1'b0, add_a} + {1'b0, add_b};

  four_cycle_a: assert property ( // RULE10
    accept && dec_now.cycles == CYC_FOUR |=>
      !fetch_ready [*3] ##1 fetch_ready)
    else $error("four cycle instruction timing wrong");
  three_cycle_a: assert property ( // RULE9
    accept && dec_now.cycles == CYC_THREE |=>
      !fetch_ready [*2] ##1 fetch_ready)
    else $error("three cycle instruction timing wrong");
  two_cycle_a: assert property ( // RULE2
    accept && dec_now.cycles == CYC_TWO |=> !fetch_ready ##1 fetch_ready)
    else $error("two cycle instruction timing wrong");
  one_cycle_a: assert property ( // RULE1
    accept && op_class == CL_NOP |=> fetch_ready && info.len == LEN_ONE)
    else $error("nop not single cycle");
  busy_ignore_a: assert property ( // RULE22
    issue && busy |=> info == $past(info))
    else $error("issue taken while busy");
  rmw_latch_a: assert property ( // RULE15
    accept && dest_is_port && dec_now.rmw |=>
      operand == $past(port_latch))
    else $error("rmw port read did not use latch");
  pin_read_a: assert property ( // RULE16
    accept && dest_is_port && !dec_now.rmw |=> operand == $past(port_pin))
    else $error("port input did not use pin");
  bit_only_a: assert property ( // RULE18
    accept && dest_is_port && dec_now.bit_write |=>
      ((port_wr_data ^ $past(port_latch)) & ~$past(bit_mask)) == 8'h00)
    else $error("bit write altered other bits");
  test_clear_a: assert property ( // RULE11
    accept && op_class == CL_BIT_TEST_CLEAR && dest_is_port &&
    port_latch[bit_sel] |=> port_wr_en && port_wr_data[$past(bit_sel)] == 0)
    else $error("test clear jump left bit set");
  add_carry_a: assert property ( // RULE19
    add_go |=> add_flags.carry == $past(chk_sum[8]) &&
      add_sum == $past(chk_sum[7:0]))
    else $error("add carry or sum wrong");
  add_wrap_a: assert property ( // RULE20
    add_go |=> add_flags.signed_wrap_flag ==
      ($past(add_a[7]) == $past(add_b[7]) &&
       add_sum[7] != $past(add_a[7])))
    else $error("signed wrap flag wrong");
  add_half_a: assert property ( // RULE21
    add_go && add_a[3:0] == 4'hf && add_b[3:0] != 4'h0 |=>
      add_flags.half_carry_flag)
    else $error("half carry flag missed");
  code_load_a: assert property ( // RULE5
    accept && op_class == CL_CODE_LOAD |=>
      info.len == LEN_ONE && info.cycles == CYC_FOUR)
    else $error("code memory load timing wrong");
  long_len_a: assert property ( // RULE10
    accept && op_class == CL_LONG_JUMP |=>
      info.len == LEN_THREE && info.cycles == CYC_FOUR)
    else $error("long jump length wrong");
  wr_port_only_a: assert property ( // RULE18
    port_wr_en |-> $past(accept) && $past(dest_is_port))
    else $error("port write without port destination");
  // unknown classes must still release the fetch after one cycle
  unknown_class_a: assert property ( // RULE22
    accept && !dec_now.known |=> fetch_ready && !info.known)
    else $error("unknown class not treated as one cycle");

  long_jump_c: cover property (accept && op_class == CL_LONG_JUMP);
  back_to_back_c: cover property (accept ##1 accept);
  port_bit_c: cover property (accept && dest_is_port && dec_now.bit_write);
  wrap_c: cover property (add_go ##1 add_flags.signed_wrap_flag);
  refused_c: cover property (issue && busy);
endmodule
`default_nettype wire

// ===== inc/mit_pkg.sv
// shared types and constants of the instruction timing unit
`default_nettype none
package mit_pkg;
  // instruction classes handed over by the opcode decoder
  typedef enum logic [4:0] {
    CL_NOP = 5'b0_0000,
    CL_ROT_ACC = 5'b0_0001,
    CL_REG_ACC = 5'b0_0010,
    CL_CARRY_OP = 5'b0_0011,
    CL_IND_MOVE = 5'b0_0100,
    CL_IND_XCH = 5'b0_0101,
    CL_NIBBLE_XCH = 5'b0_0110,
    CL_DIR_DIR = 5'b0_0111,
    CL_IMM_DIR = 5'b0_1000,
    CL_TWO_BYTE_MOVE = 5'b0_1001,
    CL_LOAD_PTR = 5'b0_1010,
    CL_CODE_LOAD = 5'b0_1011,
    CL_EXT_MOVE = 5'b0_1100,
    CL_PUSH_POP = 5'b0_1101,
    CL_BIT_WRITE = 5'b0_1110,
    CL_BIT_LOGIC = 5'b0_1111,
    CL_SHORT_BRANCH = 5'b1_0000,
    CL_JUMP_INDIRECT = 5'b1_0001,
    CL_LONG_JUMP = 5'b1_0010,
    CL_RETURN = 5'b1_0011,
    CL_BIT_JUMP = 5'b1_0100,
    CL_BIT_TEST_CLEAR = 5'b1_0101,
    CL_COMPARE_JUMP = 5'b1_0110,
    CL_DECREMENT_JUMP_NONZERO_REG = 5'b1_0111,
    CL_DECREMENT_JUMP_NONZERO_DIR = 5'b1_1000,
    CL_ABS_JUMP = 5'b1_1001,
    CL_RMW_BYTE = 5'b1_1010
  } mit_class_t;

  // how a single-bit write alters the addressed bit
  typedef enum logic [1:0] {
    BF_CLEAR = 2'b00,
    BF_SET = 2'b01,
    BF_INVERT = 2'b10,
    BF_FROM_CARRY = 2'b11
  } mit_bit_func_t;

  typedef struct packed {
    logic known;
    logic [1:0] len;
    logic [2:0] cycles;
    logic rmw;
    logic bit_write;
  } mit_info_t;

  typedef struct packed {
    logic carry;
    logic signed_wrap_flag;
    logic half_carry_flag;
  } mit_flags_t;

  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] CYC_FOUR = 3'h4;
  localparam logic [2:0] CNT_RESET = 3'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam int BIT_CARRY = 7;
  localparam int BIT_WRAP = 6;
  localparam int BIT_HALF = 3;
endpackage
`default_nettype wire

// ===== sim/mcu_instruction_timing_test.sv
// self-checking bench of the instruction timing unit
`default_nettype none
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin \
  n_mismatch++; $display("wrong value %s exp %h seen %h", nm, e, s); end end
module mcu_instruction_timing_test;
  timeunit 1ns;
  timeprecision 1ps;
  import mit_pkg::*;
  typedef struct packed {
    logic kn;
    logic [1:0] len;
    logic [2:0] cyc;
    logic [7:0] opd;
    logic bv;
    logic we;
    logic [7:0] wd;
  } mit_exp_t;
  // {length, cycles} per class, in class encoding order
  localparam logic [7:0] TBL [27] = '{8'h11, 8'h11, 8'h11, 8'h11, 8'h12,
    8'h12, 8'h12, 8'h33, 8'h33, 8'h22, 8'h33, 8'h14, 8'h14, 8'h22, 8'h22,
    8'h22, 8'h23, 8'h13, 8'h34, 8'h14, 8'h34, 8'h34, 8'h34, 8'h23, 8'h34,
    8'h23, 8'h22};
  localparam logic [15:0] CORN [6] = '{16'h7f01, 16'hff01, 16'h0f01,
    16'h8080, 16'hffff, 16'h0000};
  logic core_clk, rst, issue, dest_is_port, carry_in, add_go;
  mit_class_t op_class;
  mit_bit_func_t bit_func;
  logic [7:0] mem_data, port_latch, port_pin, add_a, add_b;
  logic [2:0] bit_sel;
  logic fetch_ready, busy, bit_val, port_wr_en;
  mit_info_t info;
  logic [7:0] operand, port_wr_data, add_sum;
  mit_flags_t add_flags;
  mit_exp_t iq[$];
  mit_exp_t ie;
  logic [10:0] aq[$];
  logic [10:0] ae;
  logic acc_q, add_q;
  int seed, n_mismatch, cmp_count;

  mit_core u_mit_core (.core_clk(core_clk), .rst(rst), .issue(issue),
    .op_class(op_class), .bit_func(bit_func), .dest_is_port(dest_is_port),
    .mem_data(mem_data), .carry_in(carry_in), .port_latch(port_latch),
    .port_pin(port_pin), .bit_sel(bit_sel), .add_go(add_go),
    .add_a(add_a), .add_b(add_b), .fetch_ready(fetch_ready), .busy(busy),
    .info(info), .operand(operand), .bit_val(bit_val),
    .port_wr_data(port_wr_data), .port_wr_en(port_wr_en),
    .add_sum(add_sum), .add_flags(add_flags));

  task automatic wrap_up();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic do_op(input int c);
    logic [7:0] md, pl, wd;
    logic [2:0] bs;
    logic dp, ci, rm, nb, st;
    mit_bit_func_t bf;
    mit_exp_t e;
    int n;
    md = 8'($random(seed));
    pl = 8'($random(seed));
    bs = 3'($random(seed));
    ci = 1'($random(seed));
    bf = mit_bit_func_t'(2'($random(seed)));
    // a register operand can never be a port
    dp = (c == CL_DECREMENT_JUMP_NONZERO_REG) ? 1'b0 : 1'($random(seed));
    rm = c == CL_RMW_BYTE || c == CL_BIT_WRITE || c == CL_BIT_TEST_CLEAR ||
      c == CL_DECREMENT_JUMP_NONZERO_DIR;
    e.opd = !dp ? md : (rm ? pl : ~pl);
    e.bv = e.opd[bs];
    case (bf)
      BF_CLEAR: nb = 1'b0;
      BF_SET: nb = 1'b1;
      BF_INVERT: nb = ~pl[bs];
      default: nb = ci;
    endcase
    if (c == CL_BIT_TEST_CLEAR) begin
      nb = 1'b0;
    end
    wd = pl;
    wd[bs] = nb;
    e.wd = wd;
    e.we = dp && (c == CL_BIT_WRITE || (c == CL_BIT_TEST_CLEAR && pl[bs]));
    e.kn = c < 27;
    e.len = e.kn ? TBL[c][5:4] : LEN_ONE;
    e.cyc = e.kn ? TBL[c][2:0] : CYC_ONE;
    st = e.cyc > CYC_ONE && 1'($random(seed));
    @(posedge core_clk);
    issue <= 1'b1;
    op_class <= mit_class_t'(5'(c));
    bit_func <= bf;
    dest_is_port <= dp;
    mem_data <= md;
    carry_in <= ci;
    port_latch <= pl;
    // pins read the opposite of the latch so the source is visible
    port_pin <= ~pl;
    bit_sel <= bs;
    iq.push_back(e);
    @(posedge core_clk);
    // a stray request while busy must be refused and leave info alone
    issue <= st;
    op_class <= mit_class_t'(5'($random(seed)));
    n = 0;
    @(negedge core_clk);
    while (fetch_ready !== 1'b1 && n < 8) begin
      n++;
      `CHK("busy", 1'b1, busy)
      @(posedge core_clk);
      issue <= 1'b0;
      @(negedge core_clk);
    end
    `CHK("busy_cycles", 32'(e.cyc) - 1, n)
    `CHK("held_cycles", e.cyc, info.cycles)
    if (n >= 8) begin
      n_mismatch++;
      wrap_up();
    end
  endtask

  task automatic do_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic c6, c3;
    s = {1'b0, a} + {1'b0, b};
    c6 = 1'(({1'b0, a[6:0]} + {1'b0, b[6:0]}) >> 7);
    c3 = 1'(({1'b0, a[3:0]} + {1'b0, b[3:0]}) >> 4);
    @(posedge core_clk);
    add_go <= 1'b1;
    add_a <= a;
    add_b <= b;
    aq.push_back({s[7:0], s[8], c6 ^ s[8], c3});
  endtask

  always @(posedge core_clk) begin
    acc_q <= !rst && issue && fetch_ready;
    add_q <= !rst && add_go;
  end

  always @(negedge core_clk) begin
    if (acc_q) begin
      `CHK("pending_op", 1'b1, iq.size() != 0)
      if (iq.size() != 0) begin
        ie = iq.pop_front();
        `CHK("known", ie.kn, info.known)
        `CHK("len", ie.len, info.len)
        `CHK("len", ie.len, info.len)
        `CHK("len", ie.len, info.len)
        `CHK("cycles", ie.cyc, info.cycles)
        `CHK("cycles", ie.cyc, info.cycles)
        `CHK("cycles", ie.cyc, info.cycles)
        `CHK("operand", ie.opd, operand)
        `CHK("bit_val", ie.bv, bit_val)
        `CHK("wr_en", ie.we, port_wr_en)
        if (ie.we) `CHK("wr_data", ie.wd, port_wr_data)
      end
    end
    if (add_q) begin
      `CHK("pending_add", 1'b1, aq.size() != 0)
      if (aq.size() != 0) begin
        ae = aq.pop_front();
        `CHK("sum_flags", ae, {add_sum, add_flags})
      end
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  initial begin
    #100000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    seed = 32'haae4;
    {rst, issue, dest_is_port, carry_in, add_go} = 5'h1_0;
    op_class = CL_NOP;
    bit_func = BF_CLEAR;
    {mem_data, port_latch, port_pin, add_a, add_b} = 40'h0;
    bit_sel = 3'h0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    `CHK("ready_rst", 1'b1, fetch_ready)
    `CHK("busy_rst", 1'b0, busy)
    `CHK("wr_en_rst", 1'b0, port_wr_en)
    fork
      for (int i = 0; i < 150; i++) begin
        do_op(i < 32 ? i : int'({$random(seed)} % 27));
      end
      begin
        for (int i = 0; i < 6; i++) begin
          do_add(CORN[i][15:8], CORN[i][7:0]);
        end
        for (int i = 0; i < 60; i++) begin
          do_add(8'($random(seed)), 8'($random(seed)));
        end
        @(posedge core_clk);
        add_go <= 1'b0;
      end
    join
    repeat (3) @(negedge core_clk);
    `CHK("drained", 0, iq.size() + aq.size())
    wrap_up();
  end
endmodule
`default_nettype wire
